/* temp_ctrl_monitor_pkg.sv */
// constants for the temperature/control monitor and rectifier mode block
`default_nettype none
package temp_ctrl_monitor_pkg;
    // timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned T_BIAS_MS = 25;
    localparam int unsigned T_DEGLITCH_MS = 10;
    localparam int unsigned T_FLOAT_MS = 100;
    localparam int unsigned BIAS_CYC = T_BIAS_MS * CYC_PER_MS;
    localparam int unsigned DEGLITCH_CYC = T_DEGLITCH_MS * CYC_PER_MS;
    localparam int unsigned FLOAT_CYC = T_FLOAT_MS * CYC_PER_MS;
    localparam int unsigned CNT_W = 26;
    // analog comparator input vector positions
    localparam int unsigned N_CMP = 9;
    localparam int unsigned CMP_HOT = 0;
    localparam int unsigned CMP_COLD = 1;
    localparam int unsigned CMP_CTRL_HI = 2;
    localparam int unsigned CMP_CTRL_LO = 3;
    localparam int unsigned CMP_UVLO_OK = 4;
    localparam int unsigned CMP_DIE_SD = 5;
    localparam int unsigned CMP_DIE_HYS_OK = 6;
    localparam int unsigned CMP_LOAD_SR = 7;
    localparam int unsigned CMP_LOAD_SRH = 8;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_LOSS = 8'h10;
    localparam logic [7:0] REG_RX_PWR = 8'h14;
    // control fields
    localparam int unsigned CTRL_MON_EN = 0;
    localparam int unsigned CTRL_SD_CLR = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    // interrupt bits
    localparam int unsigned N_IRQ = 5;
    localparam int unsigned IRQ_TEMP = 0;
    localparam int unsigned IRQ_DONE = 1;
    localparam int unsigned IRQ_FAULT = 2;
    localparam int unsigned IRQ_TSD = 3;
    localparam int unsigned IRQ_FULL = 4;
    // power report
    localparam int unsigned PWR_W = 16;
    localparam logic [15:0] LOSS_RESET = 16'h0000;
    // shutdown reason codes, rectifier modes and sequencer states
    typedef enum logic [1:0] {REASON_NONE, REASON_DONE, REASON_FAULT} reason_t;
    typedef enum logic [1:0] {SR_DIODE, SR_HALF, SR_FULL} sr_mode_t;
    typedef enum logic [1:0] {SEQ_WAIT, SEQ_BIAS, SEQ_FLOAT} seq_t;
endpackage
`default_nettype wire

/* temp_ctrl_monitor.sv */
// temperature/control pin sequencer, shutdown, thermal and rectifier mode logic
`default_nettype none
module temp_ctrl_monitor #(
    parameter int unsigned BIAS_CYC = temp_ctrl_monitor_pkg::BIAS_CYC,
    parameter int unsigned DEGLITCH_CYC = temp_ctrl_monitor_pkg::DEGLITCH_CYC,
    parameter int unsigned FLOAT_CYC = temp_ctrl_monitor_pkg::FLOAT_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_cmp_hot,
    input wire logic i_cmp_cold,
    input wire logic i_cmp_ctrl_hi,
    input wire logic i_cmp_ctrl_lo,
    input wire logic i_rect_above_uvlo,
    input wire logic i_die_at_shutdown,
    input wire logic i_die_below_hys,
    input wire logic i_load_above_full_sync,
    input wire logic i_load_below_half_return,
    input wire logic [15:0] i_out_pwr,
    input wire logic i_temp_pin_i,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_temp_bias_window,
    output logic o_temp_pin_o,
    output logic o_temp_pin_oe,
    output logic [1:0] o_sr_mode,
    output logic o_ldo_en,
    output logic o_rx_shutdown,
    output logic [1:0] o_shutdown_reason,
    output logic o_charge_allow,
    output logic o_ctrl_flag,
    output logic [15:0] o_rx_pwr,
    output logic o_irq
);
    localparam int unsigned W = temp_ctrl_monitor_pkg::CNT_W;
    localparam int unsigned N = temp_ctrl_monitor_pkg::N_CMP;
    localparam int unsigned NI = temp_ctrl_monitor_pkg::N_IRQ;

    logic [N-1:0] raw;
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [1:0] filt_q;
    logic [W-1:0] deg_cnt_q [2];
    logic [W-1:0] seq_cnt_q;
    temp_ctrl_monitor_pkg::seq_t seq_q;
    temp_ctrl_monitor_pkg::sr_mode_t sr_q;
    temp_ctrl_monitor_pkg::reason_t reason_q;
    logic tsd_q;
    logic sd_q;
    logic flag_q;
    logic [1:0] ctrl_q;
    logic [NI-1:0] irq_stat_q;
    logic [NI-1:0] irq_mask_q;
    logic [NI-1:0] ev;
    logic [15:0] loss_q;
    logic [16:0] pwr_sum;
    logic [15:0] pwr_q;
    logic bias_end;
    logic float_end;
    logic temp_bad;
    logic wr;
    logic rd_ok;
    logic [31:0] rd_d;

    assign raw = {i_load_below_half_return, i_load_above_full_sync, i_die_below_hys,
                  i_die_at_shutdown, i_rect_above_uvlo, i_cmp_ctrl_lo, i_cmp_ctrl_hi,
                  i_cmp_cold, i_cmp_hot};

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end

    assign bias_end = (seq_q == temp_ctrl_monitor_pkg::SEQ_BIAS) &&
                      (seq_cnt_q == W'(BIAS_CYC - 1));
    assign float_end = (seq_q == temp_ctrl_monitor_pkg::SEQ_FLOAT) &&
                       (seq_cnt_q == W'(FLOAT_CYC - 1));

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            seq_q <= temp_ctrl_monitor_pkg::SEQ_WAIT;
            seq_cnt_q <= '0;
        end
        else
        begin
            unique case (seq_q)
                temp_ctrl_monitor_pkg::SEQ_WAIT:
                begin
                    seq_cnt_q <= '0;
                    if (sync_q[temp_ctrl_monitor_pkg::CMP_UVLO_OK] &&
                        ctrl_q[temp_ctrl_monitor_pkg::CTRL_MON_EN])
                    begin
                        seq_q <= temp_ctrl_monitor_pkg::SEQ_BIAS;
                    end
                end
                temp_ctrl_monitor_pkg::SEQ_BIAS:
                begin
                    seq_cnt_q <= bias_end ? '0 : seq_cnt_q + W'(1);
                    if (bias_end)
                    begin
                        seq_q <= temp_ctrl_monitor_pkg::SEQ_FLOAT;
                    end
                end
                temp_ctrl_monitor_pkg::SEQ_FLOAT:
                begin
                    seq_cnt_q <= float_end ? '0 : seq_cnt_q + W'(1);
                    if (float_end)
                    begin
                        if (sync_q[temp_ctrl_monitor_pkg::CMP_UVLO_OK] &&
                            ctrl_q[temp_ctrl_monitor_pkg::CTRL_MON_EN])
                        begin
                            seq_q <= temp_ctrl_monitor_pkg::SEQ_BIAS;
                        end
                        else
                        begin
                            seq_q <= temp_ctrl_monitor_pkg::SEQ_WAIT;
                        end
                    end
                end
            endcase
        end
    end

    // pin drive follows the window
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_temp_bias_window <= 1'b0;
            o_temp_pin_o <= 1'b0;
            o_temp_pin_oe <= 1'b0;
        end
        else
        begin
            o_temp_bias_window <= (seq_q == temp_ctrl_monitor_pkg::SEQ_BIAS) && !bias_end ||
                                  (seq_q == temp_ctrl_monitor_pkg::SEQ_WAIT) &&
                                  sync_q[temp_ctrl_monitor_pkg::CMP_UVLO_OK] &&
                                  ctrl_q[temp_ctrl_monitor_pkg::CTRL_MON_EN] ||
                                  float_end && sync_q[temp_ctrl_monitor_pkg::CMP_UVLO_OK] &&
                                  ctrl_q[temp_ctrl_monitor_pkg::CTRL_MON_EN];
            o_temp_pin_o <= 1'b1;
            o_temp_pin_oe <= (seq_q == temp_ctrl_monitor_pkg::SEQ_BIAS) && !bias_end ||
                             (seq_q == temp_ctrl_monitor_pkg::SEQ_WAIT) &&
                             sync_q[temp_ctrl_monitor_pkg::CMP_UVLO_OK] &&
                             ctrl_q[temp_ctrl_monitor_pkg::CTRL_MON_EN] ||
                             float_end && sync_q[temp_ctrl_monitor_pkg::CMP_UVLO_OK] &&
                             ctrl_q[temp_ctrl_monitor_pkg::CTRL_MON_EN];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_deg
            always_ff @(posedge i_clk_sys or negedge i_rstn)
            begin
                if (!i_rstn)
                begin
                    deg_cnt_q[g] <= '0;
                    filt_q[g] <= 1'b0;
                end
                else if (seq_q != temp_ctrl_monitor_pkg::SEQ_BIAS || sync_q[g] == filt_q[g])
                begin
                    deg_cnt_q[g] <= '0;
                end
                else if (deg_cnt_q[g] == W'(DEGLITCH_CYC - 1))
                begin
                    deg_cnt_q[g] <= '0;
                    filt_q[g] <= sync_q[g];
                end
                else
                begin
                    deg_cnt_q[g] <= deg_cnt_q[g] + W'(1);
                end
            end
        end
    endgenerate

    assign temp_bad = filt_q[temp_ctrl_monitor_pkg::CMP_HOT] |
                      filt_q[temp_ctrl_monitor_pkg::CMP_COLD];

    // control pin shutdown and flag
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sd_q <= 1'b0;
            flag_q <= 1'b0;
            reason_q <= temp_ctrl_monitor_pkg::REASON_NONE;
        end
        else if (seq_q == temp_ctrl_monitor_pkg::SEQ_FLOAT && !sd_q &&
                 sync_q[temp_ctrl_monitor_pkg::CMP_CTRL_HI])
        begin
            flag_q <= 1'b1;
            sd_q <= 1'b1;
            reason_q <= temp_ctrl_monitor_pkg::REASON_DONE;
        end
        else if (seq_q == temp_ctrl_monitor_pkg::SEQ_FLOAT && !sd_q &&
                 sync_q[temp_ctrl_monitor_pkg::CMP_CTRL_LO])
        begin
            sd_q <= 1'b1;
            reason_q <= temp_ctrl_monitor_pkg::REASON_FAULT;
        end
        else if (wr && i_wb_adr == temp_ctrl_monitor_pkg::REG_CTRL && i_wb_sel[0] &&
                 i_wb_dat[temp_ctrl_monitor_pkg::CTRL_SD_CLR])
        begin
            sd_q <= 1'b0;
            flag_q <= 1'b0;
            reason_q <= temp_ctrl_monitor_pkg::REASON_NONE;
        end
    end

    // die thermal shutdown latch
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tsd_q <= 1'b0;
        end
        else if (sync_q[temp_ctrl_monitor_pkg::CMP_DIE_SD])
        begin
            tsd_q <= 1'b1;
        end
        else if (sync_q[temp_ctrl_monitor_pkg::CMP_DIE_HYS_OK])
        begin
            tsd_q <= 1'b0;
        end
    end

    // rectifier mode selection
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sr_q <= temp_ctrl_monitor_pkg::SR_DIODE;
        end
        else if (!sync_q[temp_ctrl_monitor_pkg::CMP_UVLO_OK])
        begin
            sr_q <= temp_ctrl_monitor_pkg::SR_DIODE;
        end
        else
        begin
            unique case (sr_q)
                temp_ctrl_monitor_pkg::SR_DIODE:
                    sr_q <= temp_ctrl_monitor_pkg::SR_HALF;
                temp_ctrl_monitor_pkg::SR_HALF:
                    if (sync_q[temp_ctrl_monitor_pkg::CMP_LOAD_SR])
                    begin
                        sr_q <= temp_ctrl_monitor_pkg::SR_FULL;
                    end
                // back to half on low load
                temp_ctrl_monitor_pkg::SR_FULL:
                    if (sync_q[temp_ctrl_monitor_pkg::CMP_LOAD_SRH])
                    begin
                        sr_q <= temp_ctrl_monitor_pkg::SR_HALF;
                    end
                default:
                    sr_q <= temp_ctrl_monitor_pkg::SR_DIODE;
            endcase
        end
    end

    assign pwr_sum = {1'b0, i_out_pwr} + {1'b0, loss_q};

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pwr_q <= '0;
        end
        else
        begin
            pwr_q <= pwr_sum[16] ? 16'hffff : pwr_sum[15:0];
        end
    end

    // output flops
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_sr_mode <= temp_ctrl_monitor_pkg::SR_DIODE;
            o_ldo_en <= 1'b0;
            o_rx_shutdown <= 1'b0;
            o_shutdown_reason <= temp_ctrl_monitor_pkg::REASON_NONE;
            o_charge_allow <= 1'b0;
            o_ctrl_flag <= 1'b0;
            o_rx_pwr <= '0;
            o_irq <= 1'b0;
        end
        else
        begin
            o_sr_mode <= sr_q;
            o_ldo_en <= sync_q[temp_ctrl_monitor_pkg::CMP_UVLO_OK] && !tsd_q && !sd_q;
            o_rx_shutdown <= sd_q;
            o_shutdown_reason <= reason_q;
            o_charge_allow <= sync_q[temp_ctrl_monitor_pkg::CMP_UVLO_OK] && !tsd_q &&
                              !sd_q && !temp_bad;
            o_ctrl_flag <= flag_q;
            o_rx_pwr <= pwr_q;
            o_irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // interrupt events
    assign ev[temp_ctrl_monitor_pkg::IRQ_TEMP] = bias_end & temp_bad;
    assign ev[temp_ctrl_monitor_pkg::IRQ_DONE] = sd_q & ~o_rx_shutdown &
        (reason_q == temp_ctrl_monitor_pkg::REASON_DONE);
    assign ev[temp_ctrl_monitor_pkg::IRQ_FAULT] = sd_q & ~o_rx_shutdown &
        (reason_q == temp_ctrl_monitor_pkg::REASON_FAULT);
    assign ev[temp_ctrl_monitor_pkg::IRQ_TSD] = sync_q[temp_ctrl_monitor_pkg::CMP_DIE_SD] &
        ~tsd_q;
    assign ev[temp_ctrl_monitor_pkg::IRQ_FULL] = (sr_q == temp_ctrl_monitor_pkg::SR_HALF) &&
        sync_q[temp_ctrl_monitor_pkg::CMP_UVLO_OK] &&
        sync_q[temp_ctrl_monitor_pkg::CMP_LOAD_SR];

    // bus slave
    assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ctrl_q <= temp_ctrl_monitor_pkg::CTRL_RESET;
            irq_mask_q <= '0;
            loss_q <= temp_ctrl_monitor_pkg::LOSS_RESET;
        end
        else if (wr)
        begin
            if (i_wb_adr == temp_ctrl_monitor_pkg::REG_CTRL && i_wb_sel[0])
            begin
                ctrl_q[temp_ctrl_monitor_pkg::CTRL_MON_EN] <=
                    i_wb_dat[temp_ctrl_monitor_pkg::CTRL_MON_EN];
            end
            if (i_wb_adr == temp_ctrl_monitor_pkg::REG_IRQ_MASK && i_wb_sel[0])
            begin
                irq_mask_q <= i_wb_dat[NI-1:0];
            end
            if (i_wb_adr == temp_ctrl_monitor_pkg::REG_LOSS)
            begin
                if (i_wb_sel[0])
                begin
                    loss_q[7:0] <= i_wb_dat[7:0];
                end
                if (i_wb_sel[1])
                begin
                    loss_q[15:8] <= i_wb_dat[15:8];
                end
            end
        end
    end

    // sticky status, set beats clear
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            irq_stat_q <= '0;
        end
        else if (wr && i_wb_adr == temp_ctrl_monitor_pkg::REG_IRQ_STAT && i_wb_sel[0])
        begin
            irq_stat_q <= (irq_stat_q & ~i_wb_dat[NI-1:0]) | ev;
        end
        else
        begin
            irq_stat_q <= irq_stat_q | ev;
        end
    end

    always_comb
    begin
        rd_d = '0;
        rd_ok = 1'b1;
        unique case (i_wb_adr)
            temp_ctrl_monitor_pkg::REG_CTRL:
                rd_d[0] = ctrl_q[temp_ctrl_monitor_pkg::CTRL_MON_EN];
            temp_ctrl_monitor_pkg::REG_STATUS:
                rd_d[13:0] = {seq_q, filt_q, reason_q, flag_q, sd_q, tsd_q, sr_q,
                              o_charge_allow, o_ldo_en, o_temp_bias_window};
            temp_ctrl_monitor_pkg::REG_IRQ_STAT:
                rd_d[NI-1:0] = irq_stat_q;
            temp_ctrl_monitor_pkg::REG_IRQ_MASK:
                rd_d[NI-1:0] = irq_mask_q;
            temp_ctrl_monitor_pkg::REG_LOSS:
                rd_d[15:0] = loss_q;
            temp_ctrl_monitor_pkg::REG_RX_PWR:
                rd_d[15:0] = pwr_q;
            default:
                rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= '0;
        end
        else
        begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
            o_wb_dat <= (i_wb_cyc && i_wb_stb && !i_wb_we && rd_ok) ? rd_d : '0;
        end
    end
endmodule
`default_nettype wire

/* temp_ctrl_monitor_props.sv */
// port assertions for the temperature/control monitor
`default_nettype none
module temp_ctrl_monitor_props #(
    parameter int unsigned BIAS_CYC = 40,
    parameter int unsigned FLOAT_CYC = 60
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_rect_above_uvlo,
    input wire logic i_die_at_shutdown,
    input wire logic i_load_above_full_sync,
    input wire logic i_load_below_half_return,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire logic o_temp_bias_window,
    input wire logic o_temp_pin_oe,
    input wire logic [1:0] o_sr_mode,
    input wire logic o_ldo_en,
    input wire logic o_rx_shutdown,
    input wire logic [1:0] o_shutdown_reason,
    input wire logic o_ctrl_flag
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);
    logic [31:0] hi_cnt_q;
    logic [31:0] lo_cnt_q;
    logic seen_q;
    // run lengths of window high and low
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            hi_cnt_q <= '0;
            lo_cnt_q <= '0;
            seen_q <= 1'b0;
        end
        else
        begin
            hi_cnt_q <= o_temp_bias_window ? hi_cnt_q + 32'h1 : 32'h0;
            lo_cnt_q <= o_temp_bias_window ? 32'h0 : lo_cnt_q + 32'h1;
            seen_q <= seen_q | (hi_cnt_q != 32'h0 && !o_temp_bias_window);
        end
    end
    property p_sync_off;
        !i_rect_above_uvlo [*5] |-> o_sr_mode == 2'h0;
    endproperty
    a_sync_off: assert property (p_sync_off) else $error("sync on below uvlo");
    property p_half;
        (i_rect_above_uvlo && !i_load_above_full_sync && i_load_below_half_return) [*6]
            |-> o_sr_mode == 2'h1;
    endproperty
    a_half: assert property (p_half) else $error("not half sync");
    property p_full;
        (i_rect_above_uvlo && i_load_above_full_sync) [*6] |-> o_sr_mode == 2'h2;
    endproperty
    a_full: assert property (p_full) else $error("not full sync");
    property p_bias_len;
        $fell(o_temp_bias_window) |-> hi_cnt_q == BIAS_CYC;
    endproperty
    a_bias_len: assert property (p_bias_len) else $error("window length wrong");
    property p_pin_rel;
        o_temp_pin_oe == o_temp_bias_window;
    endproperty
    a_pin_rel: assert property (p_pin_rel) else $error("pin drive outside window");
    property p_float_len;
        $rose(o_temp_bias_window) && seen_q |-> lo_cnt_q == FLOAT_CYC;
    endproperty
    a_float_len: assert property (p_float_len) else $error("float length wrong");
    property p_flag_float;
        $rose(o_ctrl_flag) |-> $past(o_temp_bias_window, 3) == 1'b0;
    endproperty
    a_flag_float: assert property (p_flag_float) else $error("flag outside float");
    property p_done;
        $rose(o_ctrl_flag) |-> o_rx_shutdown && o_shutdown_reason == 2'h1;
    endproperty
    a_done: assert property (p_done) else $error("done reason wrong");
    property p_fault;
        $rose(o_rx_shutdown) && !o_ctrl_flag |-> o_shutdown_reason == 2'h2;
    endproperty
    a_fault: assert property (p_fault) else $error("fault reason wrong");
    property p_die_off;
        i_die_at_shutdown [*5] |-> !o_ldo_en;
    endproperty
    a_die_off: assert property (p_die_off) else $error("regulator on when hot");
    property p_ack;
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack wrong");
    c_done: cover property ($rose(o_ctrl_flag));
    c_fault: cover property ($rose(o_rx_shutdown) && !o_ctrl_flag);
    c_full: cover property ($rose(o_sr_mode == 2'h2));
endmodule
bind temp_ctrl_monitor temp_ctrl_monitor_props #(.BIAS_CYC(BIAS_CYC), .FLOAT_CYC(FLOAT_CYC))
    u_props (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_rect_above_uvlo(i_rect_above_uvlo),
    .i_die_at_shutdown(i_die_at_shutdown), .i_load_above_full_sync(i_load_above_full_sync),
    .i_load_below_half_return(i_load_below_half_return), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_temp_bias_window(o_temp_bias_window),
    .o_temp_pin_oe(o_temp_pin_oe), .o_sr_mode(o_sr_mode), .o_ldo_en(o_ldo_en),
    .o_rx_shutdown(o_rx_shutdown), .o_shutdown_reason(o_shutdown_reason),
    .o_ctrl_flag(o_ctrl_flag));
`default_nettype wire

/* temp_pin_partner.sv */
// thermistor divider or host on the temperature/control pin
`default_nettype none
module temp_pin_partner (
    input wire logic [2:0] i_mode,
    input wire logic i_pin_o,
    input wire logic i_pin_oe,
    output logic o_cmp_hot,
    output logic o_cmp_cold,
    output logic o_cmp_ctrl_hi,
    output logic o_cmp_ctrl_lo,
    output logic o_pin
);
    // divider only answers while biased
    assign o_cmp_hot = i_pin_oe && i_mode == 3'h1;
    assign o_cmp_cold = i_pin_oe && i_mode == 3'h4;
    assign o_cmp_ctrl_hi = !i_pin_oe && i_mode == 3'h2;
    assign o_cmp_ctrl_lo = i_mode == 3'h3;
    assign o_pin = i_pin_oe ? i_pin_o : i_mode == 3'h2;
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench for the temperature/control monitor
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0;
    logic i_rstn = 1'b0;
    logic uvlo = 1'b0, die_sd = 1'b0, die_hys = 1'b1, ld_full = 1'b0, ld_half = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [15:0] out_pwr = 16'h0000, rx_pwr;
    logic [2:0] mode = 3'h0;
    logic hot, cold, chi, clo, pin, ack, win, pin_o, oe, ldo, sd, allow, flag, irq;
    logic [1:0] sr, reason;
    int errors = 0;
    int check_count = 0;
    int cnt;
    initial forever #2 i_clk_sys = ~i_clk_sys;
    temp_pin_partner far (.i_mode(mode), .i_pin_o(pin_o), .i_pin_oe(oe), .o_cmp_hot(hot),
        .o_cmp_cold(cold), .o_cmp_ctrl_hi(chi), .o_cmp_ctrl_lo(clo), .o_pin(pin));
    temp_ctrl_monitor #(.BIAS_CYC(40), .DEGLITCH_CYC(8), .FLOAT_CYC(60)) uut (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_cmp_hot(hot), .i_cmp_cold(cold),
        .i_cmp_ctrl_hi(chi), .i_cmp_ctrl_lo(clo), .i_rect_above_uvlo(uvlo),
        .i_die_at_shutdown(die_sd), .i_die_below_hys(die_hys), .i_load_above_full_sync(ld_full),
        .i_load_below_half_return(ld_half), .i_out_pwr(out_pwr), .i_temp_pin_i(pin),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_temp_bias_window(win),
        .o_temp_pin_o(pin_o), .o_temp_pin_oe(oe), .o_sr_mode(sr), .o_ldo_en(ldo),
        .o_rx_shutdown(sd), .o_shutdown_reason(reason), .o_charge_allow(allow),
        .o_ctrl_flag(flag), .o_rx_pwr(rx_pwr), .o_irq(irq));
    task automatic conclude(input bit tmo);
        if (tmo)
        begin
            errors++;
            $display("mismatch at %0t: wait ran out", $time);
        end
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge i_clk_sys);
        while (ack !== 1'b1)
        begin
            n++;
            if (n > 20)
                conclude(1'b1);
            @(posedge i_clk_sys);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic temp_bits(input logic [1:0] exp);
        logic [31:0] q;
        wb(1'b0, 8'h04, 32'h0, q);
        chk({30'h0, q[11:10]}, {30'h0, exp});
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic wait_win(input logic lvl);
        int n;
        n = 0;
        while (win !== lvl)
        begin
            n++;
            if (n > 300)
                conclude(1'b1);
            @(negedge i_clk_sys);
        end
    endtask
    task automatic set_mode(input logic [2:0] m);
        @(posedge i_clk_sys);
        mode <= m;
    endtask
    initial
    begin
        repeat (12) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        idle(8);
        chk(sr, 2'h0);
        chk(win, 1'b0);
        rd(8'h00, 32'h1);
        rd(8'h0c, 32'h0);
        rd(8'h1c, 32'h0);
        wr(8'h14, 32'hffff);
        rd(8'h14, 32'h0);
        wr(8'h0c, 32'h1f);
        @(posedge i_clk_sys);
        uvlo <= 1'b1;
        idle(6);
        chk(sr, 2'h1);
        @(posedge i_clk_sys);
        ld_full <= 1'b1;
        ld_half <= 1'b0;
        idle(6);
        chk(sr, 2'h2);
        chk(irq, 1'b1);
        rd(8'h08, 32'h10);
        wr(8'h08, 32'h10);
        rd(8'h08, 32'h0);
        wr(8'h0c, 32'h0f);
        @(posedge i_clk_sys);
        ld_full <= 1'b0;
        idle(8);
        chk(sr, 2'h2);
        @(posedge i_clk_sys);
        ld_half <= 1'b1;
        idle(6);
        chk(sr, 2'h1);
        chk(irq, 1'b0);
        wr(8'h0c, 32'h1f);
        wait_win(1'b0);
        wait_win(1'b1);
        chk({oe, pin_o}, 2'h3);
        cnt = 0;
        while (win === 1'b1 && cnt < 100)
        begin
            cnt++;
            idle(1);
        end
        chk(cnt, 40);
        chk(oe, 1'b0);
        set_mode(3'h1);
        wait_win(1'b1);
        wait_win(1'b0);
        idle(3);
        temp_bits(2'b01);
        chk(allow, 1'b0);
        chk(irq, 1'b1);
        rd(8'h08, 32'h1);
        wr(8'h08, 32'h1);
        set_mode(3'h4);
        wait_win(1'b1);
        wait_win(1'b0);
        idle(3);
        temp_bits(2'b10);
        wr(8'h08, 32'h1);
        set_mode(3'h0);
        wait_win(1'b1);
        wait_win(1'b0);
        idle(3);
        temp_bits(2'b00);
        chk(allow, 1'b1);
        wait_win(1'b1);
        set_mode(3'h1);
        idle(5);
        set_mode(3'h0);
        wait_win(1'b0);
        idle(3);
        temp_bits(2'b00);
        set_mode(3'h2);
        idle(8);
        chk(flag, 1'b1);
        chk({sd, reason}, 3'b101);
        rd(8'h08, 32'h2);
        set_mode(3'h0);
        wr(8'h00, 32'h3);
        wr(8'h08, 32'h2);
        chk({flag, sd, reason}, 4'h0);
        wait_win(1'b1);
        set_mode(3'h3);
        wait_win(1'b0);
        idle(8);
        chk({flag, sd, reason}, 4'b0110);
        rd(8'h08, 32'h4);
        set_mode(3'h0);
        wr(8'h00, 32'h2);
        wr(8'h08, 32'h4);
        chk(ldo, 1'b1);
        @(posedge i_clk_sys);
        die_sd <= 1'b1;
        die_hys <= 1'b0;
        idle(6);
        chk(ldo, 1'b0);
        rd(8'h08, 32'h8);
        @(posedge i_clk_sys);
        die_sd <= 1'b0;
        idle(99);
        chk({win, ldo}, 2'h0);
        @(posedge i_clk_sys);
        die_hys <= 1'b1;
        idle(6);
        chk(ldo, 1'b1);
        wr(8'h08, 32'h8);
        wr(8'h10, 32'h64);
        @(posedge i_clk_sys);
        out_pwr <= 16'h1000;
        idle(4);
        chk(rx_pwr, 16'h1064);
        rd(8'h14, 32'h1064);
        @(posedge i_clk_sys);
        out_pwr <= 16'hfff0;
        idle(4);
        chk(rx_pwr, 16'hffff);
        @(posedge i_clk_sys);
        i_rstn <= 1'b0;
        idle(3);
        chk({win, sr}, 3'h0);
        @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        wait_win(1'b1);
        conclude(1'b0);
    end
endmodule
`default_nettype wire
